/* hdl/pin_irq_pkg.sv */
// Constants for the external pin interrupt logic
`default_nettype none
package pin_irq_pkg;
    localparam int          ADDR_W        = 8;
    // Register byte offsets
    localparam logic [7:0]  OFS_FLAG      = 8'h00;
    localparam logic [7:0]  OFS_ENABLE    = 8'h04;
    localparam logic [7:0]  OFS_BUSCTL    = 8'h08;
    localparam logic [7:0]  OFS_TIMCTL    = 8'h0C;
    localparam logic [7:0]  OFS_CAPTURE   = 8'h10;
    // Pin / flag bit positions (same layout in flag and enable registers)
    localparam int          BIT_RISE_A    = 0;
    localparam int          BIT_RISE_B    = 1;
    localparam int          BIT_FALL_A    = 2;
    localparam int          BIT_CAPTURE   = 3;
    localparam int          BIT_FALL_B    = 4;
    localparam int          BIT_FALL_C    = 5;
    localparam int          BIT_NONMASK   = 6;
    localparam int          BIT_LEVEL     = 7;
    localparam int          PIN_CNT       = 8;
    // Control bit positions
    localparam int          BIT_ABORT_EN  = 5;
    localparam int          BIT_NMI_EN    = 6;
    localparam int          BIT_SEL_LO    = 2;
    localparam int          BIT_SEL_HI    = 3;
    // Reset values
    localparam logic [7:0]  RST_FLAG      = 8'h00;
    localparam logic [7:0]  RST_ENABLE    = 8'h00;
    localparam logic [7:0]  RST_BUSCTL    = 8'h00;
    localparam logic [7:0]  RST_TIMCTL    = 8'h00;
    localparam logic [15:0] RST_CAPTURE   = 16'h0000;
    localparam logic [7:0]  PIN_IDLE      = 8'hFF;
endpackage : pin_irq_pkg
`default_nettype wire

/* hdl/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter and edge pulses
`default_nettype none
module pin_sync import pin_irq_pkg::*; #(
    parameter int         W     = 8,
    parameter logic [7:0] IDLE  = PIN_IDLE
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] lvl,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                s1_q[i] <= IDLE[i];
                s2_q[i] <= IDLE[i];
                s3_q[i] <= IDLE[i];
                lvl[i]  <= IDLE[i];
                rise[i] <= 1'b0;
                fall[i] <= 1'b0;
            end else begin
                s1_q[i] <= pin[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                // Only an agreed value moves the level; one-cycle glitches die here
                if (s2_q[i] == s3_q[i]) begin
                    lvl[i] <= s3_q[i];
                end
                rise[i] <= (s2_q[i] == s3_q[i]) && s3_q[i] && !lvl[i];
                fall[i] <= (s2_q[i] == s3_q[i]) && !s3_q[i] && lvl[i];
            end
        end
    end
endmodule : pin_sync
`default_nettype wire

/* hdl/external_pin_interrupt_logic.sv */
// External pin interrupt logic with APB register access
// Functional notes
// [R1] Rising edge on rise pins sets flag
// [R2] Falling edge on rise pins ignored
// [R3] Falling edge on fall pins sets flag
// [R4] Rising edge on fall pins ignored
// [R5] Request needs enable set, disable flag clear
// [R6] Level pin low shows in flag bit7
// [R7] Level request needs enable bit7, disable clear
// [R8] Level request not latched, follows pin
// [R9] Nonmask enable: every falling edge interrupts
// [R10] Nonmask request ignores interrupt disable flag
// [R11] Abort enable bit arms abort function
// [R12] Both enables: both functions active together
// [R13] Selected capture edge copies timer counter
// [R14] Each capture sets edge flag bit3
// [R15] Edge flags sticky until software clears
//
// The register offsets and the APB interface to the registers were left to the implementer.
`default_nettype none
module external_pin_interrupt_logic import pin_irq_pkg::*; #(
    parameter int CNT_W = 16
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              rise_irq_in_a,
    input  wire logic              rise_irq_in_b,
    input  wire logic              fall_irq_in_a,
    input  wire logic              fall_irq_in_b,
    input  wire logic              fall_irq_in_c,
    input  wire logic              level_irq_n,
    input  wire logic              nonmask_irq_n,
    input  wire logic              capture_in,
    input  wire logic [CNT_W-1:0]  timer_seven_count,
    input  wire logic              cpu_irq_disable,
    output logic                   irq,
    output logic                   cpu_irq,
    output logic                   nmi_req,
    output logic                   abort_req_n
);
    logic [PIN_CNT-1:0] pins;
    logic [PIN_CNT-1:0] lvl;
    logic [PIN_CNT-1:0] rise;
    logic [PIN_CNT-1:0] fall;
    logic [6:0]         flag_q;
    logic [6:0]         flag_d;
    logic [6:0]         flag_set;
    logic [6:0]         flag_clr;
    logic [7:0]         en_q;
    logic [7:0]         busctl_q;
    logic [7:0]         timctl_q;
    logic [CNT_W-1:0]   cap_q;
    logic [7:0]         irq_status;
    logic               nm_en;
    logic               abort_en;
    logic               cap_evt;
    logic               wr_en;
    logic               rd_setup;
    logic               addr_ok;
    logic [31:0]        rd_d;

    assign pins[BIT_RISE_A]  = rise_irq_in_a;
    assign pins[BIT_RISE_B]  = rise_irq_in_b;
    assign pins[BIT_FALL_A]  = fall_irq_in_a;
    assign pins[BIT_CAPTURE] = capture_in;
    assign pins[BIT_FALL_B]  = fall_irq_in_b;
    assign pins[BIT_FALL_C]  = fall_irq_in_c;
    assign pins[BIT_NONMASK] = nonmask_irq_n;
    assign pins[BIT_LEVEL]   = level_irq_n;

    pin_sync #(
        .W    (PIN_CNT),
        .IDLE (PIN_IDLE)
    ) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (pins),
        .lvl     (lvl),
        .rise    (rise),
        .fall    (fall)
    );

    assign nm_en    = busctl_q[BIT_NMI_EN];
    assign abort_en = busctl_q[BIT_ABORT_EN];
    // Both edges selected means capture on each edge
    assign cap_evt  = (timctl_q[BIT_SEL_LO] && rise[BIT_CAPTURE])
                   || (timctl_q[BIT_SEL_HI] && fall[BIT_CAPTURE]); // [R13]

    // APB decode; slave never waits
    assign pready   = 1'b1;
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    always_comb begin
        addr_ok = (paddr == OFS_FLAG) || (paddr == OFS_ENABLE) || (paddr == OFS_BUSCTL)
               || (paddr == OFS_TIMCTL) || (paddr == OFS_CAPTURE);
    end
    assign pslverr  = psel && penable && !addr_ok;

    // Edge flag sources
    always_comb begin
        flag_set              = 7'h00;
        flag_set[BIT_RISE_A]  = rise[BIT_RISE_A]; // [R1] [R2]
        flag_set[BIT_RISE_B]  = rise[BIT_RISE_B]; // [R1] [R2]
        flag_set[BIT_FALL_A]  = fall[BIT_FALL_A]; // [R3] [R4]
        flag_set[BIT_FALL_B]  = fall[BIT_FALL_B]; // [R3] [R4]
        flag_set[BIT_FALL_C]  = fall[BIT_FALL_C]; // [R3] [R4]
        flag_set[BIT_CAPTURE] = cap_evt; // [R14]
        flag_set[BIT_NONMASK] = fall[BIT_NONMASK] && nm_en;
    end

    always_comb begin
        flag_clr = 7'h00;
        if (wr_en && paddr == OFS_FLAG) begin
            flag_clr = pwdata[6:0];
        end
        // Set beats clear so an edge in the clearing cycle survives
        flag_d = (flag_q & ~flag_clr) | flag_set; // [R15]
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag_q <= RST_FLAG[6:0];
        end else begin
            flag_q <= flag_d; // [R15]
        end
    end

    // Bit7 is live from the pin, never stored
    assign irq_status = {!lvl[BIT_LEVEL], flag_q}; // [R6] [R8]

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            en_q     <= RST_ENABLE;
            busctl_q <= RST_BUSCTL;
            timctl_q <= RST_TIMCTL;
        end else if (wr_en) begin
            if (paddr == OFS_ENABLE) begin
                en_q <= pwdata[7:0];
            end
            if (paddr == OFS_BUSCTL) begin
                busctl_q <= pwdata[7:0];
            end
            if (paddr == OFS_TIMCTL) begin
                timctl_q <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cap_q <= RST_CAPTURE[CNT_W-1:0];
        end else if (cap_evt) begin
            cap_q <= timer_seven_count; // [R13]
        end
    end

    // Interrupt outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq     <= 1'b0;
            cpu_irq <= 1'b0;
        end else begin
            irq     <= |(irq_status & en_q); // [R8]
            cpu_irq <= |(irq_status & en_q) && !cpu_irq_disable; // [R5] [R7]
        end
    end

    // Nonmask and abort share one pin; both may run at once
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            nmi_req     <= 1'b0;
            abort_req_n <= 1'b1;
        end else begin
            nmi_req     <= fall[BIT_NONMASK] && nm_en; // [R9] [R10] [R12]
            abort_req_n <= !(abort_en && !lvl[BIT_NONMASK]); // [R11] [R12]
        end
    end

    // Read data is captured in setup so it is from flip-flops in access
    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (paddr)
            OFS_FLAG:    rd_d[7:0] = irq_status;
            OFS_ENABLE:  rd_d[7:0] = en_q;
            OFS_BUSCTL:  rd_d[7:0] = busctl_q;
            OFS_TIMCTL:  rd_d[7:0] = timctl_q;
            OFS_CAPTURE: rd_d[CNT_W-1:0] = cap_q;
            default:     rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= rd_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_rise_sets_flag: assert property ( // [R1]
        rise[BIT_RISE_A] |=> flag_q[BIT_RISE_A])
        else $error("rise edge did not set flag");

    a_rise_fall_quiet: assert property ( // [R2]
        $rose(flag_q[BIT_RISE_A]) |-> $past(rise[BIT_RISE_A]))
        else $error("rise flag set without rising edge");

    a_fall_sets_flag: assert property ( // [R3]
        fall[BIT_FALL_A] |=> flag_q[BIT_FALL_A])
        else $error("fall edge did not set flag");

    a_fall_rise_quiet: assert property ( // [R4]
        $rose(flag_q[BIT_FALL_A]) |-> $past(fall[BIT_FALL_A]))
        else $error("fall flag set without falling edge");

    a_cpu_irq_gated: assert property ( // [R5]
        cpu_irq |-> $past(!cpu_irq_disable && ((irq_status & en_q) != 8'h00)))
        else $error("cpu request without enabled flag or while disabled");

    a_level_in_flag: assert property ( // [R6]
        (!lvl[BIT_LEVEL] && rd_setup && paddr == OFS_FLAG) |=> prdata[BIT_LEVEL])
        else $error("level pin low not shown in flag bit7");

    a_level_requests: assert property ( // [R7]
        (!lvl[BIT_LEVEL] && en_q[BIT_LEVEL] && !cpu_irq_disable) |=> cpu_irq)
        else $error("enabled level request not delivered");

    a_level_not_held: assert property ( // [R8]
        (lvl[BIT_LEVEL] && ((en_q[6:0] & flag_q) == 7'h00)) |=> !irq)
        else $error("level request held after pin released");

    a_nmi_on_fall: assert property ( // [R9]
        (fall[BIT_NONMASK] && nm_en) |=> nmi_req ##1 !nmi_req)
        else $error("nonmask falling edge not a one-cycle request");

    a_nmi_unmasked: assert property ( // [R10]
        (fall[BIT_NONMASK] && nm_en && cpu_irq_disable) |=> nmi_req)
        else $error("nonmask request blocked by disable flag");

    a_abort_follows: assert property ( // [R11]
        (abort_en && !lvl[BIT_NONMASK]) |=> !abort_req_n)
        else $error("abort not raised while enabled and pin low");

    a_both_modes: assert property ( // [R12]
        (abort_en && nm_en && fall[BIT_NONMASK]) |=> (nmi_req && !abort_req_n))
        else $error("combined nonmask and abort not both active");

    a_capture_copy: assert property ( // [R13]
        cap_evt |=> (cap_q == $past(timer_seven_count)))
        else $error("capture latch missed counter value");

    a_capture_flag: assert property ( // [R14]
        cap_evt |=> flag_q[BIT_CAPTURE])
        else $error("capture did not set edge flag bit3");

    a_flag_sticky: assert property ( // [R15]
        (flag_q[BIT_FALL_B] && !(wr_en && paddr == OFS_FLAG && pwdata[BIT_FALL_B])) |=> flag_q[BIT_FALL_B])
        else $error("edge flag dropped without software clear");

    a_rise_b_sets: assert property ( // [R1]
        rise[BIT_RISE_B] |=> flag_q[BIT_RISE_B])
        else $error("second rise edge did not set flag");

    a_rise_b_quiet: assert property ( // [R2]
        $rose(flag_q[BIT_RISE_B]) |-> $past(rise[BIT_RISE_B]))
        else $error("second rise flag set without rising edge");

    a_fall_b_sets: assert property ( // [R3]
        fall[BIT_FALL_B] |=> flag_q[BIT_FALL_B])
        else $error("second fall edge did not set flag");

    a_fall_c_sets: assert property ( // [R3]
        fall[BIT_FALL_C] |=> flag_q[BIT_FALL_C])
        else $error("third fall edge did not set flag");

    a_fall_c_quiet: assert property ( // [R4]
        $rose(flag_q[BIT_FALL_C]) |-> $past(fall[BIT_FALL_C]))
        else $error("third fall flag set without falling edge");

    a_disable_blocks: assert property ( // [R5]
        cpu_irq_disable |=> !cpu_irq)
        else $error("cpu request raised while disabled");

    a_nmi_needs_en: assert property ( // [R9]
        nmi_req |-> $past(nm_en))
        else $error("nonmask request while not enabled");

    a_abort_released: assert property ( // [R11]
        lvl[BIT_NONMASK] |=> abort_req_n)
        else $error("abort held after pin released");

    // Latch must hold between captures or software reads a torn value
    a_capture_quiet: assert property ( // [R13]
        !cap_evt |=> (cap_q == $past(cap_q)))
        else $error("capture latch changed without capture edge");

    c_level_irq: cover property (!lvl[BIT_LEVEL] && en_q[BIT_LEVEL] ##1 cpu_irq);
    c_nmi_abort: cover property (nm_en && abort_en ##1 nmi_req);
    c_capture:   cover property (cap_evt ##1 flag_q[BIT_CAPTURE]);
    c_set_clear: cover property (flag_set[BIT_RISE_A] && flag_clr[BIT_RISE_A]);
    c_both_edge: cover property (timctl_q[BIT_SEL_LO] && timctl_q[BIT_SEL_HI] && cap_evt);
endmodule : external_pin_interrupt_logic
`default_nettype wire

/* verification/pin_source.sv */
// Behavioural model of the external pins feeding the interrupt logic
`default_nettype none
module pin_source (
    input  wire logic       clk,
    output var  logic [7:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;

    // All sources idle high, matching the synchroniser reset state
    initial begin
        pins = 8'hFF;
    end

    // Each level is held well beyond the filter depth so no edge is lost
    task automatic drive(input int idx, input logic val);
        @(posedge clk);
        pins[idx] <= val;
        repeat (10) @(posedge clk);
    endtask : drive
endmodule : pin_source
`default_nettype wire

/* verification/test_external_pin_interrupt_logic.sv */
// Self-checking bench for the external pin interrupt logic
`default_nettype none
module test_external_pin_interrupt_logic import pin_irq_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clk;
    logic              sys_rst;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [7:0]        pins;
    logic [15:0]       tcount;
    logic              dis;
    logic              irq;
    logic              cpu_irq;
    logic              nmi_req;
    logic              abort_req_n;
    int                fails;
    int                check_count;
    int                cyc;
    int                nmi_cnt;
    int                n0;
    int                b;
    logic [31:0]       rd;
    logic              err;
    logic [7:0]        m;
    logic [15:0]       cap_exp;
    int                edge_bits [5] = '{BIT_RISE_A, BIT_RISE_B, BIT_FALL_A, BIT_FALL_B, BIT_FALL_C};

    external_pin_interrupt_logic u_dut (
        .clk               (clk),
        .sys_rst           (sys_rst),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .rise_irq_in_a     (pins[BIT_RISE_A]),
        .rise_irq_in_b     (pins[BIT_RISE_B]),
        .fall_irq_in_a     (pins[BIT_FALL_A]),
        .fall_irq_in_b     (pins[BIT_FALL_B]),
        .fall_irq_in_c     (pins[BIT_FALL_C]),
        .level_irq_n       (pins[BIT_LEVEL]),
        .nonmask_irq_n     (pins[BIT_NONMASK]),
        .capture_in        (pins[BIT_CAPTURE]),
        .timer_seven_count (tcount),
        .cpu_irq_disable   (dis),
        .irq               (irq),
        .cpu_irq           (cpu_irq),
        .nmi_req           (nmi_req),
        .abort_req_n       (abort_req_n)
    );

    pin_source u_src (
        .clk  (clk),
        .pins (pins)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // One-cycle pulses are counted at every edge so none is missed
    always @(posedge clk) begin
        if (sys_rst) nmi_cnt <= 0;
        else if (nmi_req === 1'b1) nmi_cnt <= nmi_cnt + 1;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            fails = fails + 1;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Idle cycle first, so psel is never assigned twice in one step
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No local limit; the cycle timeout ends a hung wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask : rd_chk

    task automatic settle();
        repeat (3) @(posedge clk);
    endtask : settle

    task automatic final_report();
        $display("Checks %0d, errors %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report

    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0000_0000;
        tcount = 16'h0000;
        dis = 1'b0;
        fails = 0;
        check_count = 0;
        cyc = 0;
        cap_exp = 16'h0000;
        void'($urandom(32'hE2A0));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        for (b = 0; b < 5; b++) rd_chk(ADDR_W'(b * 4), 32'h0000_0000);
        apb(1'b0, 8'h14, 32'h0000_0000);
        chk({31'h0, err}, 32'h1);
        chk({31'h0, pready}, 32'h1);
        chk(rd, 32'h0);
        wr(OFS_CAPTURE, {16'h0, 16'($urandom())});
        rd_chk(OFS_CAPTURE, 32'h0);
        foreach (edge_bits[i]) begin
            b = edge_bits[i];
            u_src.drive(b, 1'b0);
            rd_chk(OFS_FLAG, (b <= BIT_RISE_B) ? 32'h0 : 32'h1 << b);
            wr(OFS_FLAG, 32'h1 << b);
            rd_chk(OFS_FLAG, 32'h0);
            u_src.drive(b, 1'b1);
            repeat (20) @(posedge clk);
            rd_chk(OFS_FLAG, (b <= BIT_RISE_B) ? 32'h1 << b : 32'h0);
            wr(OFS_FLAG, 32'h1 << b);
            rd_chk(OFS_FLAG, 32'h0);
        end
        u_src.drive(BIT_RISE_A, 1'b0);
        u_src.drive(BIT_RISE_A, 1'b1);
        m = 8'($urandom()) & 8'h7E;
        wr(OFS_ENABLE, {24'h0, m});
        settle();
        chk({30'h0, irq, cpu_irq}, 32'h0);
        wr(OFS_ENABLE, {24'h0, m | 8'h01});
        rd_chk(OFS_ENABLE, {24'h0, m | 8'h01});
        chk({30'h0, irq, cpu_irq}, 32'h3);
        dis <= 1'b1;
        settle();
        chk({30'h0, irq, cpu_irq}, 32'h2);
        wr(OFS_FLAG, 32'h1);
        settle();
        chk({31'h0, irq}, 32'h0);
        wr(OFS_ENABLE, 32'h80);
        dis <= 1'b0;
        u_src.drive(BIT_LEVEL, 1'b0);
        rd_chk(OFS_FLAG, 32'h80);
        chk({31'h0, cpu_irq}, 32'h1);
        dis <= 1'b1;
        settle();
        chk({31'h0, cpu_irq}, 32'h0);
        dis <= 1'b0;
        repeat (30) @(posedge clk);
        chk({31'h0, cpu_irq}, 32'h1);
        u_src.drive(BIT_LEVEL, 1'b1);
        rd_chk(OFS_FLAG, 32'h0);
        chk({31'h0, cpu_irq}, 32'h0);
        dis <= 1'b1;
        for (b = 0; b < 4; b++) begin
            m = 8'(((b & 1) << 6) | ((b & 2) << 4));
            wr(OFS_BUSCTL, {24'h0, m});
            n0 = nmi_cnt;
            u_src.drive(BIT_NONMASK, 1'b0);
            chk({31'h0, abort_req_n}, {31'h0, ~m[BIT_ABORT_EN]});
            u_src.drive(BIT_NONMASK, 1'b1);
            chk({31'h0, abort_req_n}, 32'h1);
            u_src.drive(BIT_NONMASK, 1'b0);
            u_src.drive(BIT_NONMASK, 1'b1);
            chk(32'(nmi_cnt - n0), m[BIT_NMI_EN] ? 32'h2 : 32'h0);
            wr(OFS_FLAG, 32'h7F);
        end
        dis <= 1'b0;
        for (b = 0; b < 4; b++) begin
            m = 8'(b << 2);
            wr(OFS_TIMCTL, {24'h0, m});
            tcount <= 16'($urandom());
            u_src.drive(BIT_CAPTURE, 1'b0);
            if (m[BIT_SEL_HI]) cap_exp = tcount;
            rd_chk(OFS_FLAG, {28'h0, m[BIT_SEL_HI], 3'h0});
            rd_chk(OFS_CAPTURE, {16'h0, cap_exp});
            wr(OFS_FLAG, 32'h8);
            tcount <= 16'($urandom());
            u_src.drive(BIT_CAPTURE, 1'b1);
            if (m[BIT_SEL_LO]) cap_exp = tcount;
            rd_chk(OFS_FLAG, {28'h0, m[BIT_SEL_LO], 3'h0});
            rd_chk(OFS_CAPTURE, {16'h0, cap_exp});
            wr(OFS_FLAG, 32'h8);
        end
        final_report();
    end
endmodule : test_external_pin_interrupt_logic
`default_nettype wire
